//--- design/frs_top.sv
/* frs_top: selector with APB registers, records and carrier control.
   Assumes all inputs are synchronous to clk_sys. */
// Behaviour
// - value 2 clears faults, times, energy
// - initialization setting returns to zero afterwards
// - carrier mode: 0 fixed, 1 auto, 2 quiet
// - auto mode lowers carrier while heatsink hot
// - auxiliary selector decodes nine channel codes
// - Y alone handled like main X
// - digital Y overlay is up/down increment only
// - analog/pulse 100% maps to configured range as overlay, to maximum frequency as Y alone
// - range base: maximum frequency or main X
// - range percent 0..150, overlay modes only
// - units digit picks target frequency source
// - tens digit picks sum, difference, max, min
// - mode 2: switch terminal picks X or Y
// - mode 3: switch picks X or combined
// - mode 4: switch picks Y or combined
// - max/min compare absolute values
// - offset added to combined result
`timescale 1ns/1ps
`default_nettype none
module frs_top
    import frs_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [frs_pkg::AW-1:0] paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // frequency sources
    input  wire logic [frs_pkg::FW-1:0] main_x,
    input  wire logic [frs_pkg::FW-1:0] analog_input_one,
    input  wire logic [frs_pkg::FW-1:0] analog_input_two_or_current,
    input  wire logic [frs_pkg::FW-1:0] pulse_input_terminal,
    input  wire logic [frs_pkg::FW-1:0] mspeed_freq,
    input  wire logic [frs_pkg::FW-1:0] pid_freq,
    input  wire logic [frs_pkg::FW-1:0] comm_freq,
    input  wire logic [frs_pkg::FW-1:0] seq_freq,
    input  wire logic [frs_pkg::FW-1:0] pot_freq,
    // terminals and keys
    input  wire logic                freq_switch,
    input  wire logic                up_step,
    input  wire logic                down_step,
    // record events
    input  wire logic                run_tick,
    input  wire logic                pon_tick,
    input  wire logic [15:0]         energy_inc,
    input  wire logic                fault_event,
    // thermal
    input  wire logic                heatsink_hot,
    // results
    output logic [frs_pkg::SW-1:0]   target_freq,
    output logic [7:0]               carrier_eff,
    output logic                     low_noise
);
    typedef enum logic [2:0] {
        FRS_IDLE    = 3'b001,
        FRS_CLEAR   = 3'b010,
        FRS_RESTORE = 3'b100
    } frs_init_e;

    frs_init_e     state_reg, state_next;
    logic [1:0]    init_reg, init_next;
    logic [1:0]    cmode_reg, cmode_next;
    logic [7:0]    cset_reg, cset_next;
    logic [3:0]    aux_sel_reg, aux_sel_next;
    logic          base_reg, base_next;
    logic [7:0]    rpct_reg, rpct_next;
    logic [3:0]    units_reg, units_next;
    logic [3:0]    tens_reg, tens_next;
    logic [FW-1:0] offset_reg, offset_next;
    logic [FW-1:0] preset_reg, preset_next;
    logic [FW-1:0] maxf_reg, maxf_next;
    logic [SW-1:0] acc_reg, acc_next;
    logic [31:0]   run_reg, run_next;
    logic [31:0]   pon_reg, pon_next;
    logic [31:0]   energy_reg, energy_next;
    logic [15:0]   faults_reg, faults_next;
    logic [SW-1:0] target_reg, target_next;
    logic [7:0]    ceff_reg, ceff_next;
    logic          quiet_reg, quiet_next;
    logic [31:0]   rdata_reg, rdata_next;
    logic          ready_reg, ready_next;
    logic          err_reg, err_next;
    logic          wr_en;
    logic          hit;
    logic [31:0]   rd_val;
    logic [SW-1:0] y_alone;
    logic [SW-1:0] y_super;
    logic [SW-1:0] target_comb;
    logic [7:0]    half_carrier;
    frs_aux_scale u_aux (
        .aux_sel                     (aux_sel_reg),
        .range_base                  (base_reg),
        .range_pct                   (rpct_reg),
        .max_freq                    (maxf_reg),
        .keypad_preset               (preset_reg),
        .updown_acc                  (acc_reg),
        .main_x                      (main_x),
        .analog_input_one            (analog_input_one),
        .analog_input_two_or_current (analog_input_two_or_current),
        .pulse_input_terminal        (pulse_input_terminal),
        .mspeed_freq                 (mspeed_freq),
        .pid_freq                    (pid_freq),
        .comm_freq                   (comm_freq),
        .seq_freq                    (seq_freq),
        .pot_freq                    (pot_freq),
        .y_alone                     (y_alone),
        .y_super                     (y_super)
    );
    frs_combine u_comb (
        .sel_units     (units_reg),
        .sel_tens      (tens_reg),
        .comb_offset   (offset_reg),
        .switch_active (freq_switch),
        .main_x        (main_x),
        .y_alone       (y_alone),
        .y_super       (y_super),
        .target        (target_comb)
    );

    // read decode
    always_comb begin
        hit    = 1'b1;
        rd_val = '0;
        if (paddr == OFF_INIT) begin
            rd_val = 32'(init_reg);
        end else if (paddr == OFF_CARR_MODE) begin
            rd_val = 32'(cmode_reg);
        end else if (paddr == OFF_CARR_SET) begin
            rd_val = 32'(cset_reg);
        end else if (paddr == OFF_AUX_SEL) begin
            rd_val = 32'(aux_sel_reg);
        end else if (paddr == OFF_AUX_BASE) begin
            rd_val = 32'(base_reg);
        end else if (paddr == OFF_AUX_PCT) begin
            rd_val = 32'(rpct_reg);
        end else if (paddr == OFF_OVERLAY) begin
            rd_val = 32'({tens_reg, units_reg});
        end else if (paddr == OFF_OFFSET) begin
            rd_val = 32'(offset_reg);
        end else if (paddr == OFF_PRESET) begin
            rd_val = 32'(preset_reg);
        end else if (paddr == OFF_MAX_FREQ) begin
            rd_val = 32'(maxf_reg);
        end else if (paddr == OFF_TARGET) begin
            rd_val = 32'($signed(target_reg));
        end else if (paddr == OFF_CARR_EFF) begin
            rd_val = 32'(ceff_reg);
        end else if (paddr == OFF_RUN_TIME) begin
            rd_val = run_reg;
        end else if (paddr == OFF_PON_TIME) begin
            rd_val = pon_reg;
        end else if (paddr == OFF_ENERGY) begin
            rd_val = energy_reg;
        end else if (paddr == OFF_FAULTS) begin
            rd_val = 32'(faults_reg);
        end else if (paddr == OFF_STATUS) begin
            rd_val = {acc_reg, 9'h000, freq_switch, heatsink_hot, state_reg};
        end else begin
            hit = 1'b0;
        end
    end

    // apb handshake: one wait state, then registered answer
    always_comb begin
        ready_next = psel & penable & ~ready_reg;
        rdata_next = rdata_reg;
        err_next   = 1'b0;
        if (psel & penable & ~ready_reg) begin
            rdata_next = pwrite ? '0 : rd_val;
            err_next   = ~hit;
        end
        wr_en = psel & penable & ready_reg & pwrite & ~err_reg;
    end

    // configuration, sequencer and counters
    always_comb begin
        state_next   = state_reg;
        init_next    = init_reg;
        cmode_next   = cmode_reg;
        cset_next    = cset_reg;
        aux_sel_next = aux_sel_reg;
        base_next    = base_reg;
        rpct_next    = rpct_reg;
        units_next   = units_reg;
        tens_next    = tens_reg;
        offset_next  = offset_reg;
        preset_next  = preset_reg;
        maxf_next    = maxf_reg;
        acc_next     = acc_reg;
        run_next     = run_reg + 32'(run_tick);
        pon_next     = pon_reg + 32'(pon_tick);
        energy_next  = energy_reg + 32'(energy_inc);
        faults_next  = faults_reg + 16'(fault_event);
        if (up_step & ~down_step & ($signed(acc_reg) < $signed({2'b00, maxf_reg}))) begin
            acc_next = acc_reg + UPDOWN_STEP;
        end else if (down_step & ~up_step
                     & ($signed(acc_reg) > -$signed({2'b00, maxf_reg}))) begin
            acc_next = acc_reg - UPDOWN_STEP;
        end
        if (wr_en) begin
            if (paddr == OFF_INIT) begin
                init_next = pwdata[1:0];
            end else if (paddr == OFF_CARR_MODE) begin
                if (pwdata <= 32'(CARR_QUIET)) cmode_next = pwdata[1:0];
            end else if (paddr == OFF_CARR_SET) begin
                cset_next = pwdata[7:0];
            end else if (paddr == OFF_AUX_SEL) begin
                aux_sel_next = pwdata[3:0];
            end else if (paddr == OFF_AUX_BASE) begin
                base_next = pwdata[0];
            end else if (paddr == OFF_AUX_PCT) begin
                rpct_next = (pwdata > 32'(RANGE_MAX)) ? RANGE_MAX : pwdata[7:0];
            end else if (paddr == OFF_OVERLAY) begin
                units_next = pwdata[3:0];
                tens_next  = pwdata[7:4];
            end else if (paddr == OFF_OFFSET) begin
                offset_next = pwdata[FW-1:0];
            end else if (paddr == OFF_PRESET) begin
                preset_next = pwdata[FW-1:0];
            end else if (paddr == OFF_MAX_FREQ) begin
                maxf_next = pwdata[FW-1:0];
            end
        end
        case (state_reg)
            FRS_IDLE: begin
                if (init_reg == INIT_CLEAR) state_next = FRS_CLEAR;
                else if (init_reg == INIT_RESTORE) state_next = FRS_RESTORE;
            end
            FRS_CLEAR: begin
                // a tick in the clear cycle is kept
                run_next    = 32'(run_tick);
                pon_next    = 32'(pon_tick);
                energy_next = 32'(energy_inc);
                faults_next = 16'(fault_event);
                init_next   = INIT_NONE;
                state_next  = FRS_IDLE;
            end
            FRS_RESTORE: begin
                cmode_next   = CARR_MODE_RST;
                cset_next    = CARR_SET_RST;
                aux_sel_next = AUX_DIGITAL;
                base_next    = 1'b0;
                rpct_next    = RANGE_FULL;
                units_next   = SEL_X;
                tens_next    = OP_SUM;
                offset_next  = '0;
                preset_next  = MAX_FREQ_RST;
                maxf_next    = MAX_FREQ_RST;
                acc_next     = '0;
                init_next    = INIT_NONE;
                state_next   = FRS_IDLE;
            end
            default: state_next = FRS_IDLE;
        endcase
    end

    // outputs
    always_comb begin
        target_next  = target_comb;
        half_carrier = {1'b0, cset_reg[7:1]};
        quiet_next   = (cmode_reg == CARR_QUIET);
        if ((cmode_reg == CARR_AUTO) && heatsink_hot) begin
            ceff_next = (half_carrier < CARR_MIN) ? CARR_MIN : half_carrier;
        end else begin
            ceff_next = cset_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg   <= FRS_IDLE;
            init_reg    <= INIT_NONE;
            cmode_reg   <= CARR_MODE_RST;
            cset_reg    <= CARR_SET_RST;
            aux_sel_reg <= AUX_DIGITAL;
            base_reg    <= 1'b0;
            rpct_reg    <= RANGE_FULL;
            units_reg   <= SEL_X;
            tens_reg    <= OP_SUM;
            offset_reg  <= '0;
            preset_reg  <= MAX_FREQ_RST;
            maxf_reg    <= MAX_FREQ_RST;
            acc_reg     <= '0;
            run_reg     <= '0;
            pon_reg     <= '0;
            energy_reg  <= '0;
            faults_reg  <= '0;
            target_reg  <= '0;
            ceff_reg    <= CARR_SET_RST;
            quiet_reg   <= 1'b0;
            rdata_reg   <= '0;
            ready_reg   <= 1'b0;
            err_reg     <= 1'b0;
        end else begin
            state_reg   <= state_next;
            init_reg    <= init_next;
            cmode_reg   <= cmode_next;
            cset_reg    <= cset_next;
            aux_sel_reg <= aux_sel_next;
            base_reg    <= base_next;
            rpct_reg    <= rpct_next;
            units_reg   <= units_next;
            tens_reg    <= tens_next;
            offset_reg  <= offset_next;
            preset_reg  <= preset_next;
            maxf_reg    <= maxf_next;
            acc_reg     <= acc_next;
            run_reg     <= run_next;
            pon_reg     <= pon_next;
            energy_reg  <= energy_next;
            faults_reg  <= faults_next;
            target_reg  <= target_next;
            ceff_reg    <= ceff_next;
            quiet_reg   <= quiet_next;
            rdata_reg   <= rdata_next;
            ready_reg   <= ready_next;
            err_reg     <= err_next;
        end
    end

    assign prdata      = rdata_reg;
    assign pready      = ready_reg;
    assign pslverr     = err_reg;
    assign target_freq = target_reg;
    assign carrier_eff = ceff_reg;
    assign low_noise   = quiet_reg;
endmodule : frs_top
`default_nettype wire

//--- design/frs_pkg.sv
/* frs_pkg: offsets, codes, reset values and scaling of the selector.
   Assumes 0.01 Hz frequency steps and 0.1 % input steps. */
package frs_pkg;
    localparam int FW = 16;
    localparam int SW = 18;
    localparam int AW = 8;

    // byte offsets
    localparam logic [AW-1:0] OFF_INIT     = 8'h00;
    localparam logic [AW-1:0] OFF_CARR_MODE = 8'h04;
    localparam logic [AW-1:0] OFF_CARR_SET = 8'h08;
    localparam logic [AW-1:0] OFF_AUX_SEL  = 8'h0c;
    localparam logic [AW-1:0] OFF_AUX_BASE = 8'h10;
    localparam logic [AW-1:0] OFF_AUX_PCT  = 8'h14;
    localparam logic [AW-1:0] OFF_OVERLAY  = 8'h18;
    localparam logic [AW-1:0] OFF_OFFSET   = 8'h1c;
    localparam logic [AW-1:0] OFF_PRESET   = 8'h20;
    localparam logic [AW-1:0] OFF_MAX_FREQ = 8'h24;
    localparam logic [AW-1:0] OFF_TARGET   = 8'h28;
    localparam logic [AW-1:0] OFF_CARR_EFF = 8'h2c;
    localparam logic [AW-1:0] OFF_RUN_TIME = 8'h30;
    localparam logic [AW-1:0] OFF_PON_TIME = 8'h34;
    localparam logic [AW-1:0] OFF_ENERGY   = 8'h38;
    localparam logic [AW-1:0] OFF_FAULTS   = 8'h3c;
    localparam logic [AW-1:0] OFF_STATUS   = 8'h40;

    // init setting codes
    localparam logic [1:0] INIT_NONE    = 2'h0;
    localparam logic [1:0] INIT_RESTORE = 2'h1;
    localparam logic [1:0] INIT_CLEAR   = 2'h2;

    // carrier codes
    localparam logic [1:0] CARR_FIXED   = 2'h0;
    localparam logic [1:0] CARR_AUTO    = 2'h1;
    localparam logic [1:0] CARR_QUIET   = 2'h2;
    localparam logic [1:0] CARR_MODE_RST = CARR_AUTO;
    localparam logic [7:0] CARR_SET_RST = 8'h50;   // 8.0 kHz in 0.1 kHz steps
    localparam logic [7:0] CARR_MIN     = 8'h05;   // 0.5 kHz floor

    // auxiliary source codes
    localparam logic [3:0] AUX_DIGITAL = 4'h0;
    localparam logic [3:0] AUX_ANA1    = 4'h1;
    localparam logic [3:0] AUX_ANA2    = 4'h2;
    localparam logic [3:0] AUX_MSPEED  = 4'h4;
    localparam logic [3:0] AUX_PID     = 4'h5;
    localparam logic [3:0] AUX_COMM    = 4'h6;
    localparam logic [3:0] AUX_SEQ     = 4'h7;
    localparam logic [3:0] AUX_POT     = 4'h8;
    localparam logic [3:0] AUX_PULSE   = 4'h9;

    // overlay digit codes
    localparam logic [3:0] SEL_X       = 4'h0;
    localparam logic [3:0] SEL_COMB    = 4'h1;
    localparam logic [3:0] SEL_SW_XY   = 4'h2;
    localparam logic [3:0] SEL_SW_XC   = 4'h3;
    localparam logic [3:0] SEL_SW_YC   = 4'h4;
    localparam logic [3:0] OP_SUM      = 4'h0;
    localparam logic [3:0] OP_DIFF     = 4'h1;
    localparam logic [3:0] OP_MAX      = 4'h2;
    localparam logic [3:0] OP_MIN      = 4'h3;

    // scaling
    localparam logic [FW-1:0] PCT_FULL   = 16'h03e8;  // 100.0 % of an input
    localparam logic [7:0]    RANGE_FULL = 8'h64;     // 100 % of the range
    localparam logic [7:0]    RANGE_MAX  = 8'h96;     // 150 %
    localparam logic [FW-1:0] MAX_FREQ_RST = 16'h1388; // 50.00 Hz
    localparam logic [SW-1:0] UPDOWN_STEP  = 18'h00001;
endpackage : frs_pkg

//--- design/frs_aux_scale.sv
/* frs_aux_scale: picks source Y and scales it alone and as an overlay.
   Assumes steady inputs and legal range settings. */
`timescale 1ns/1ps
`default_nettype none
module frs_aux_scale
    import frs_pkg::*;
(
    // settings
    input  wire logic [3:0]    aux_sel,
    input  wire logic          range_base,
    input  wire logic [7:0]    range_pct,
    input  wire logic [FW-1:0] max_freq,
    input  wire logic [FW-1:0] keypad_preset,
    input  wire logic [SW-1:0] updown_acc,
    // sources
    input  wire logic [FW-1:0] main_x,
    input  wire logic [FW-1:0] analog_input_one,
    input  wire logic [FW-1:0] analog_input_two_or_current,
    input  wire logic [FW-1:0] pulse_input_terminal,
    input  wire logic [FW-1:0] mspeed_freq,
    input  wire logic [FW-1:0] pid_freq,
    input  wire logic [FW-1:0] comm_freq,
    input  wire logic [FW-1:0] seq_freq,
    input  wire logic [FW-1:0] pot_freq,
    // results
    output logic [SW-1:0]      y_alone,
    output logic [SW-1:0]      y_super
);
    logic [FW-1:0] pct;
    logic          is_pct;
    logic [SW-1:0] fixed;
    logic [47:0]   prod_alone;
    logic [47:0]   prod_super;
    logic [FW-1:0] base;

    always_comb begin
        pct    = '0;
        is_pct = 1'b0;
        fixed  = '0;
        case (aux_sel)
            AUX_DIGITAL: fixed = $signed({2'b00, keypad_preset}) + $signed(updown_acc);
            AUX_ANA1: begin
                pct    = analog_input_one;
                is_pct = 1'b1;
            end
            AUX_ANA2: begin
                pct    = analog_input_two_or_current;
                is_pct = 1'b1;
            end
            AUX_PULSE: begin
                pct    = pulse_input_terminal;
                is_pct = 1'b1;
            end
            AUX_MSPEED: fixed = {2'b00, mspeed_freq};
            AUX_PID:    fixed = {2'b00, pid_freq};
            AUX_COMM:   fixed = {2'b00, comm_freq};
            AUX_SEQ:    fixed = {2'b00, seq_freq};
            AUX_POT:    fixed = {2'b00, pot_freq};
            default:    fixed = '0;
        endcase
        base       = range_base ? main_x : max_freq;
        prod_alone = (48'(pct) * 48'(max_freq)) / 48'(PCT_FULL);
        prod_super = (48'(pct) * 48'(base) * 48'(range_pct))
                     / (48'(PCT_FULL) * 48'(RANGE_FULL));
        y_alone = is_pct ? prod_alone[SW-1:0] : fixed;
        if (aux_sel == AUX_DIGITAL) begin
            y_super = updown_acc;
        end else if (is_pct) begin
            y_super = prod_super[SW-1:0];
        end else begin
            y_super = fixed;
        end
    end
endmodule : frs_aux_scale
`default_nettype wire

//--- design/frs_combine.sv
/* frs_combine: combines X and Y, adds the offset, picks the target.
   Assumes X is non-negative; Y may be signed. */
`timescale 1ns/1ps
`default_nettype none
module frs_combine
    import frs_pkg::*;
(
    // settings
    input  wire logic [3:0]    sel_units,
    input  wire logic [3:0]    sel_tens,
    input  wire logic [FW-1:0] comb_offset,
    input  wire logic          switch_active,
    // operands
    input  wire logic [FW-1:0] main_x,
    input  wire logic [SW-1:0] y_alone,
    input  wire logic [SW-1:0] y_super,
    // result
    output logic [SW-1:0]      target
);
    logic [SW-1:0] x_s;
    logic [SW-1:0] op_res;
    logic [SW-1:0] comb;
    logic [SW-1:0] ay;

    function automatic logic [SW-1:0] absval(input logic [SW-1:0] v);
        absval = v[SW-1] ? SW'(-$signed(v)) : v;
    endfunction : absval

    always_comb begin
        x_s = {2'b00, main_x};
        ay  = absval(y_super);
        case (sel_tens)
            OP_SUM:  op_res = x_s + y_super;
            OP_DIFF: op_res = x_s - y_super;
            OP_MAX:  op_res = (x_s >= ay) ? x_s : y_super;
            OP_MIN:  op_res = (x_s <= ay) ? x_s : y_super;
            default: op_res = x_s + y_super;
        endcase
        comb = op_res + {2'b00, comb_offset};
        case (sel_units)
            SEL_X:     target = x_s;
            SEL_COMB:  target = comb;
            SEL_SW_XY: target = switch_active ? y_alone : x_s;
            SEL_SW_XC: target = switch_active ? comb : x_s;
            SEL_SW_YC: target = switch_active ? comb : y_alone;
            default:   target = x_s;
        endcase
    end
endmodule : frs_combine
`default_nettype wire

//--- tb/frs_props.sv
/* frs_props: port checker bound to frs_top.
   assumes carrier settings at or above the 0.5 kHz floor. */
`timescale 1ns/1ps
`default_nettype none
module frs_props
    import frs_pkg::*;
(
    // watched ports
    input wire logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, low_noise,
    input wire logic up_step, down_step, freq_switch, heatsink_hot,
    input wire logic [31:0] prdata,
    input wire logic [frs_pkg::FW-1:0] main_x, analog_input_one, analog_input_two_or_current,
    input wire logic [frs_pkg::FW-1:0] pulse_input_terminal, mspeed_freq, pid_freq, comm_freq,
    input wire logic [frs_pkg::FW-1:0] seq_freq, pot_freq,
    input wire logic [frs_pkg::SW-1:0] target_freq,
    input wire logic [7:0] carrier_eff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic wr_done = pready && pwrite;
    sequence calm;
        $stable({main_x, analog_input_one, analog_input_two_or_current, pulse_input_terminal,
            mspeed_freq, pid_freq, comm_freq, seq_freq, pot_freq, freq_switch})
            && !up_step && !down_step && !psel;
    endsequence
    pready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    access_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("ready late or early");
    ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("error with data");
    target_hold_a: assert property (calm ##1 calm ##1 calm |=> $stable(target_freq))
        else $error("target moved");
    carr_hold_a:
        assert property ((!psel && $stable(heatsink_hot))[*3] |=> $stable(carrier_eff))
        else $error("carrier moved");
    carr_drop_a:
        assert property ((!psel)[*2] ##0 $rose(heatsink_hot) |=> carrier_eff <= $past(carrier_eff))
        else $error("carrier rose on heat");
    noise_write_a: assert property ($changed(low_noise) |->
        $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3) || $past(wr_done, 4))
        else $error("low noise moved");
    cover property (pslverr);
    cover property ($rose(heatsink_hot));
    cover property (wr_done);
endmodule : frs_props
bind frs_top frs_props i_props (.*);
`default_nettype wire

//--- tb/frs_far_side.sv
/* frs_far_side: analog, pulse and fixed sources feeding frs_top.
   assumes x_val and pct_val land one edge later. */
`timescale 1ns/1ps
`default_nettype none
module frs_far_side
    import frs_pkg::*;
(
    // bench side
    input  wire logic clk_sys,
    input  wire logic [frs_pkg::FW-1:0] x_val, pct_val,
    // source lines
    output logic [frs_pkg::FW-1:0] main_x, analog_input_one, analog_input_two_or_current,
    output logic [frs_pkg::FW-1:0] pulse_input_terminal, mspeed_freq, pid_freq, comm_freq,
    output logic [frs_pkg::FW-1:0] seq_freq, pot_freq
);
    logic [FW-1:0] x_q = '0, p_q = '0;
    always @(posedge clk_sys) begin
        x_q <= x_val;
        p_q <= pct_val;
    end
    // every channel differs so a wrong pick shows
    assign main_x = x_q;
    assign analog_input_one = p_q;
    assign analog_input_two_or_current = p_q + 16'h0001;
    assign pulse_input_terminal = p_q + 16'h0002;
    assign mspeed_freq = 16'h0111;
    assign pid_freq = 16'h0222;
    assign comm_freq = 16'h0333;
    assign seq_freq = 16'h0444;
    assign pot_freq = 16'h0555;
endmodule : frs_far_side
`default_nettype wire

//--- tb/frs_bench.sv
/* frs_bench: self-checking APB bench for frs_top.
   assumes reset max frequency and preset of 5000. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module frs_bench;
    import frs_pkg::*;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, freq_switch = 0;
    logic up_step = 0, down_step = 0, run_tick = 0, pon_tick = 0, fault_event = 0;
    logic heatsink_hot = 0, pready, pslverr, err, low_noise;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [FW-1:0] energy_inc = '0, x_val = 16'h03e8, pct_val = '0, main_x, analog_input_one;
    logic [FW-1:0] analog_input_two_or_current, pulse_input_terminal, mspeed_freq, pid_freq;
    logic [FW-1:0] comm_freq, seq_freq, pot_freq;
    logic [SW-1:0] target_freq;
    logic [7:0] carrier_eff;
    int n_errors = 0, checks_done = 0, cycles = 0, seed = 67, x, a, bs, rp, u, t, off, s, k;
    frs_top i_dut (.*);
    frs_far_side i_far (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    always @(posedge clk_sys) if (++cycles == 20000) begin n_errors++; finish_test(); end
    task automatic apb(input logic w, input logic [AW-1:0] ad, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge clk_sys) penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
        @(posedge clk_sys);
    endtask : apb
    function automatic logic [SW-1:0] want(int x, ya, ys, u, t, off, sw);
        int c;
        c = off + (t == 1 ? x - ys : t == 2 ? (ys > x ? ys : x) : t == 3 ? (ys < x ? ys : x) : x + ys);
        return SW'(u == 1 || (sw && u > 2) ? c : (u == 2 && sw) || u == 4 ? ya : x);
    endfunction : want
    function automatic int rnd(int m);
        return $unsigned($random(seed)) % m;
    endfunction : rnd
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        apb(0, OFF_CARR_MODE, 0); `CHK(rd, 32'h1)
        apb(0, OFF_AUX_PCT, 0); `CHK(rd, 32'h64)
        apb(0, 8'h44, 0); `CHK(err, 1'b1)
        heatsink_hot <= 1; @(posedge clk_sys);
        for (k = 0; k < 3; k++) begin
            apb(1, OFF_CARR_MODE, k); repeat (3) @(posedge clk_sys);
            `CHK(carrier_eff, k == 1 ? 8'h28 : 8'h50)
            `CHK(low_noise, k == 2)
        end
        apb(1, OFF_CARR_MODE, 1); heatsink_hot <= 0; repeat (2) @(posedge clk_sys);
        `CHK(carrier_eff, 8'h50)
        run_tick <= 1; pon_tick <= 1; fault_event <= 1; energy_inc <= 16'h0003;
        repeat (4) @(posedge clk_sys);
        run_tick <= 0; pon_tick <= 0; fault_event <= 0; energy_inc <= '0;
        apb(0, OFF_RUN_TIME, 0); `CHK(rd, 32'h4)
        apb(1, OFF_INIT, 2); apb(0, OFF_INIT, 0); `CHK(rd, 32'h0)
        for (k = 0; k < 4; k++) begin apb(0, AW'(OFF_RUN_TIME + 4 * k), 0); `CHK(rd, 32'h0) end
        pct_val <= 16'd500; freq_switch <= 1; apb(1, OFF_OVERLAY, 2);
        for (k = 0; k < 10; k++) begin
            apb(1, OFF_AUX_SEL, k); @(posedge clk_sys);
            `CHK(target_freq, k == 0 ? 5000 : k < 3 || k == 9 ? (500 + (k == 2) + 2 * (k == 9)) * 5 : k == 3 ? 0 : 273 * (k - 3))
        end
        apb(1, OFF_AUX_SEL, 0);
        repeat (4) begin up_step <= 1; @(posedge clk_sys); up_step <= 0; @(posedge clk_sys); end
        down_step <= 1; @(posedge clk_sys); down_step <= 0;
        for (k = 0; k < 40; k++) begin
            u = k % 5; t = k / 10; s = k / 5 % 2; freq_switch <= s[0];
            apb(1, OFF_OVERLAY, 16 * t + u); @(posedge clk_sys);
            `CHK(target_freq, want(1000, 5003, 3, u, t, 0, s))
        end
        apb(1, OFF_AUX_SEL, 1);
        for (k = 0; k < 60; k++) begin
            x = rnd(5001); a = k == 0 ? 998 : rnd(999); bs = rnd(2); rp = k == 0 ? 150 : rnd(151);
            u = rnd(5); t = rnd(4); off = rnd(500); s = rnd(2);
            x_val <= 16'(x); pct_val <= 16'(a); freq_switch <= s[0];
            apb(1, OFF_AUX_BASE, bs); apb(1, OFF_AUX_PCT, rp); apb(1, OFF_OFFSET, off);
            apb(1, OFF_OVERLAY, 16 * t + u); @(posedge clk_sys);
            `CHK(target_freq, want(x, a * 5, a * (bs ? x : 5000) * rp / 100000, u, t, off, s))
        end
        apb(1, OFF_INIT, 1); apb(0, OFF_AUX_SEL, 0); `CHK(rd, 32'h0)
        finish_test();
    end
endmodule : frs_bench
`default_nettype wire
